// File: core/bfau_pkg.sv
package bfau_pkg;
   localparam logic [7:0] ADDR_INDIRECT = 8'h00;
   localparam logic [7:0] ADDR_TIMER = 8'h01;
   localparam logic [7:0] ADDR_PCL = 8'h02;
   localparam logic [7:0] ADDR_STATUS = 8'h03;
   localparam logic [7:0] ADDR_POINTER = 8'h04;
   localparam logic [7:0] ADDR_PORT_A = 8'h05;
   localparam logic [7:0] ADDR_PORT_B = 8'h06;
   localparam logic [7:0] ADDR_PC_HIGH = 8'h0A;
   localparam logic [7:0] ADDR_INT_CTRL = 8'h0B;
   localparam logic [7:0] ADDR_PIR = 8'h0C;
   localparam logic [7:0] ADDR_CMP = 8'h1F;
   localparam logic [7:0] ADDR_OPTION = 8'h81;
   localparam logic [7:0] ADDR_DIR_A = 8'h85;
   localparam logic [7:0] ADDR_DIR_B = 8'h86;
   localparam logic [7:0] ADDR_PIE = 8'h8C;
   localparam logic [7:0] ADDR_RESET_CAUSE = 8'h8E;
   localparam logic [7:0] ADDR_VREF = 8'h9F;
   localparam logic [6:0] GPR_LOW_FIRST = 7'h20;
   localparam logic [6:0] GPR_LOW_LAST = 7'h6F;
   localparam logic [6:0] COMMON_FIRST = 7'h70;
   localparam logic [6:0] GPR_HIGH_LAST = 7'h3F;
   localparam logic [6:0] BANK_MASK = 7'h7F;
   localparam logic [7:0] BANK_HIGH_BASE = 8'h80;
   localparam int C_POS = 0;
   localparam int DC_POS = 1;
   localparam int Z_POS = 2;
   localparam int PD_POS = 3;
   localparam int TO_POS = 4;
   localparam int RP0_POS = 5;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [7:0] STATUS_WRITE_MASK = 8'hE0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [7:0] DIR_RESET = 8'hFF;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ADD = 4'h1,
      OP_SUB = 4'h2,
      OP_AND = 4'h3,
      OP_IOR = 4'h4,
      OP_XOR = 4'h5,
      OP_COMPLEMENT = 4'h6,
      OP_ROTATE_LEFT = 4'h7,
      OP_ROTATE_RIGHT = 4'h8,
      OP_NIBBLE_SWAP = 4'h9,
      OP_INCREMENT = 4'hA,
      OP_DECREMENT = 4'hB,
      OP_PASS = 4'hC,
      OP_ZEROING = 4'hD,
      OP_BIT_CLEAR = 4'hE,
      OP_BIT_SET = 4'hF
   } alu_op_t;
endpackage

// File: core/bfau_alu.sv
module bfau_alu #(
   parameter int WIDTH = 8
) (
   input wire bfau_pkg::alu_op_t op,
   input wire logic [WIDTH-1:0] acc,
   input wire logic [WIDTH-1:0] opnd,
   input wire logic [2:0] bit_sel,
   input wire logic carry_in,
   output logic [WIDTH-1:0] result,
   output logic carry_out,
   output logic nibble_out,
   output logic zero_out,
   output logic affects_z,
   output logic affects_cdc
);
   logic [WIDTH:0] wide;
   logic [4:0] low;
   always_comb begin
      wide = '0;
      low = '0;
      result = opnd;
      carry_out = carry_in;
      nibble_out = 1'b0;
      affects_z = 1'b1;
      affects_cdc = 1'b0;
      case (op)
         bfau_pkg::OP_ADD: begin
            wide = {1'b0, opnd} + {1'b0, acc};
            low = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
            result = wide[WIDTH-1:0];
            carry_out = wide[WIDTH];
            nibble_out = low[4];
            affects_cdc = 1'b1;
         end
         bfau_pkg::OP_SUB: begin
            // two's complement add: carry out is the inverted borrow
            wide = {1'b0, opnd} + {1'b0, ~acc} + {{WIDTH{1'b0}}, 1'b1};
            low = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
            result = wide[WIDTH-1:0];
            carry_out = wide[WIDTH];
            nibble_out = low[4];
            affects_cdc = 1'b1;
         end
         bfau_pkg::OP_AND: result = acc & opnd;
         bfau_pkg::OP_IOR: result = acc | opnd;
         bfau_pkg::OP_XOR: result = acc ^ opnd;
         bfau_pkg::OP_COMPLEMENT: result = ~opnd;
         bfau_pkg::OP_ROTATE_LEFT: begin
            result = {opnd[WIDTH-2:0], carry_in};
            carry_out = opnd[WIDTH-1];
            affects_z = 1'b0;
            affects_cdc = 1'b1;
         end
         bfau_pkg::OP_ROTATE_RIGHT: begin
            result = {carry_in, opnd[WIDTH-1:1]};
            carry_out = opnd[0];
            affects_z = 1'b0;
            affects_cdc = 1'b1;
         end
         bfau_pkg::OP_NIBBLE_SWAP: begin
            result = {opnd[3:0], opnd[WIDTH-1:4]};
            affects_z = 1'b0;
         end
         bfau_pkg::OP_INCREMENT: result = opnd + {{(WIDTH-1){1'b0}}, 1'b1};
         bfau_pkg::OP_DECREMENT: result = opnd - {{(WIDTH-1){1'b0}}, 1'b1};
         bfau_pkg::OP_PASS: result = opnd;
         bfau_pkg::OP_ZEROING: result = '0;
         bfau_pkg::OP_BIT_CLEAR: begin
            result = opnd & ~({{(WIDTH-1){1'b0}}, 1'b1} << bit_sel);
            affects_z = 1'b0;
         end
         bfau_pkg::OP_BIT_SET: begin
            result = opnd | ({{(WIDTH-1){1'b0}}, 1'b1} << bit_sel);
            affects_z = 1'b0;
         end
         default: affects_z = 1'b0;
      endcase
      // cdc-only flag ops never clear the flag through nibble_out default
      if (!affects_cdc) begin
         nibble_out = 1'b0;
      end
      zero_out = (result == '0);
   end
endmodule // bfau_alu

// File: core/bfau_core.sv
// How it works
// - ALU works on 8-bit operands: add, subtract, rotate, logic.
// - Arithmetic is two's complement.
// - Two-operand ops use accumulator plus file or literal; single-operand use either.
// - Accumulator is 8 bits and has no data memory address.
// - ALU updates carry, nibble carry and zero flags per operation.
// - On subtract, carry and nibble carry are inverted borrows.
// - Status writes by flag-setting ops suppress flag bits; owned flags take ALU values, others hold.
// - Timeout and sleep flags ignore writes; only reset, sleep, watchdog clear, watchdog timeout.
// - Bit clear, bit set, nibble swap, accumulator store leave flags alone.
// - Status register appears identically at 03h and 83h.
// - Address zero is no storage; it redirects through the pointer.
// - Every special register, program counter low included, is file mapped.
// - Direct addressing via file field and indirect via pointer.
module bfau_core #(
   parameter bit COMMON_RAM = 1'b1,
   parameter bit HIGH_GPR = 1'b1
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic exec_valid,
   input wire bfau_pkg::alu_op_t exec_op,
   input wire logic [6:0] file_addr,
   input wire logic use_literal,
   input wire logic [7:0] literal,
   input wire logic [2:0] bit_sel,
   input wire logic dest_file,
   input wire logic sleep_cmd,
   input wire logic watchdog_clear_cmd,
   input wire logic watchdog_timeout,
   input wire logic [7:0] timer_in,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] pc_low_in,
   output logic [7:0] accumulator,
   output logic [7:0] status_flags,
   output logic [7:0] read_data,
   output logic [7:0] write_data,
   output logic [7:0] write_addr,
   output logic write_ext,
   output logic [7:0] pc_high_latch,
   output logic [7:0] interrupt_control,
   output logic [7:0] option_config,
   output logic [7:0] indirect_pointer
);
   localparam logic [6:0] RAM_WORDS = 7'h60;

   logic [7:0] acc_q;
   logic [7:0] status_q;
   logic [7:0] pointer_q;
   logic [7:0] pc_high_q;
   logic [7:0] int_ctrl_q;
   logic [7:0] option_q;
   logic [7:0] read_q;
   logic [7:0] wdata_q;
   logic [7:0] waddr_q;
   logic wext_q;
   // low bank storage includes the sixteen bytes shared with the high bank
   logic [7:0] ram_low [0:RAM_WORDS-1];
   logic [7:0] ram_high [0:31];

   logic [7:0] eff_addr;
   logic [7:0] map_addr;
   logic [6:0] off;
   logic high_bank;
   logic [7:0] file_val;
   logic file_ok;
   logic [7:0] opnd;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;
   logic alu_z;
   logic aff_z;
   logic aff_cdc;
   logic write_file;
   logic write_status;

   // indirect when the file field names address zero; bank bit for direct
   always_comb begin
      if (file_addr == bfau_pkg::ADDR_INDIRECT[6:0]) begin
         eff_addr = pointer_q;
      end else begin
         eff_addr = {status_q[bfau_pkg::RP0_POS], file_addr};
      end
      off = eff_addr[6:0];
      high_bank = eff_addr[7];
      // common ram: high bank top sixteen alias low bank
      if (COMMON_RAM && high_bank && off >= bfau_pkg::COMMON_FIRST) begin
         map_addr = {1'b0, off};
      end else begin
         map_addr = eff_addr;
      end
   end

   always_comb begin
      file_val = bfau_pkg::BYTE_ZERO;
      file_ok = 1'b1;
      case (map_addr[6:0])
         bfau_pkg::ADDR_INDIRECT[6:0]: file_ok = 1'b0; // pointer to itself reads zero
         bfau_pkg::ADDR_PCL[6:0]: file_val = pc_low_in;
         bfau_pkg::ADDR_STATUS[6:0]: file_val = status_q;
         bfau_pkg::ADDR_POINTER[6:0]: file_val = pointer_q;
         bfau_pkg::ADDR_PC_HIGH[6:0]: file_val = pc_high_q;
         bfau_pkg::ADDR_INT_CTRL[6:0]: file_val = int_ctrl_q;
         default: begin
            if (!map_addr[7]) begin
               case (map_addr[6:0])
                  bfau_pkg::ADDR_TIMER[6:0]: file_val = timer_in;
                  bfau_pkg::ADDR_PORT_A[6:0]: file_val = port_a_in;
                  bfau_pkg::ADDR_PORT_B[6:0]: file_val = port_b_in;
                  default: begin
                     if (map_addr[6:0] >= bfau_pkg::GPR_LOW_FIRST) begin
                        file_val = ram_low[7'(map_addr[6:0] - bfau_pkg::GPR_LOW_FIRST)];
                     end else begin
                        file_ok = 1'b0;
                     end
                  end
               endcase
            end else if (map_addr == bfau_pkg::ADDR_OPTION) begin
               file_val = option_q;
            end else if (HIGH_GPR && map_addr[6:0] >= bfau_pkg::GPR_LOW_FIRST
                         && map_addr[6:0] <= bfau_pkg::GPR_HIGH_LAST) begin
               file_val = ram_high[5'(map_addr[6:0] - bfau_pkg::GPR_LOW_FIRST)];
            end else begin
               file_ok = 1'b0;
            end
         end
      endcase
      opnd = use_literal ? literal : file_val;
   end

   bfau_alu #(
      .WIDTH(8)
   ) alu_i (
      .op(exec_op),
      .acc(acc_q),
      .opnd(opnd),
      .bit_sel(bit_sel),
      .carry_in(status_q[bfau_pkg::C_POS]),
      .result(alu_res),
      .carry_out(alu_c),
      .nibble_out(alu_dc),
      .zero_out(alu_z),
      .affects_z(aff_z),
      .affects_cdc(aff_cdc)
   );

   // accumulator store is a move of acc into a file: op none with dest_file
   logic [7:0] result_v;
   logic flag_op;
   assign result_v = (exec_op == bfau_pkg::OP_NONE) ? acc_q : alu_res;
   assign write_file = exec_valid && dest_file && !use_literal;
   assign write_status = write_file && map_addr[6:0] == bfau_pkg::ADDR_STATUS[6:0];
   // an op that owns any arithmetic flag blocks the byte write to all three
   assign flag_op = exec_valid && exec_op != bfau_pkg::OP_NONE && (aff_z || aff_cdc);

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         acc_q <= bfau_pkg::BYTE_ZERO;
      end else if (exec_valid && !write_file) begin
         acc_q <= result_v;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         status_q <= bfau_pkg::STATUS_RESET;
      end else begin
         if (write_status) begin
            status_q[7:5] <= result_v[7:5];
         end
         if (exec_valid && aff_z && exec_op != bfau_pkg::OP_NONE) begin
            status_q[bfau_pkg::Z_POS] <= alu_z;
         end else if (write_status && !flag_op) begin
            status_q[bfau_pkg::Z_POS] <= result_v[bfau_pkg::Z_POS];
         end
         if (exec_valid && aff_cdc) begin
            status_q[bfau_pkg::C_POS] <= alu_c;
         end else if (write_status && !flag_op) begin
            status_q[bfau_pkg::C_POS] <= result_v[bfau_pkg::C_POS];
         end
         if (exec_valid && (exec_op == bfau_pkg::OP_ADD || exec_op == bfau_pkg::OP_SUB)) begin
            status_q[bfau_pkg::DC_POS] <= alu_dc;
         end else if (write_status && !flag_op) begin
            status_q[bfau_pkg::DC_POS] <= result_v[bfau_pkg::DC_POS];
         end
         if (watchdog_clear_cmd) begin
            status_q[bfau_pkg::TO_POS] <= 1'b1;
            status_q[bfau_pkg::PD_POS] <= 1'b1;
         end else if (sleep_cmd) begin
            status_q[bfau_pkg::TO_POS] <= 1'b1;
            status_q[bfau_pkg::PD_POS] <= 1'b0;
         end else if (watchdog_timeout) begin
            status_q[bfau_pkg::TO_POS] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pointer_q <= bfau_pkg::BYTE_ZERO;
         pc_high_q <= bfau_pkg::BYTE_ZERO;
         int_ctrl_q <= bfau_pkg::BYTE_ZERO;
         option_q <= bfau_pkg::OPTION_RESET;
      end else if (write_file) begin
         case (map_addr[6:0])
            bfau_pkg::ADDR_POINTER[6:0]: pointer_q <= result_v;
            bfau_pkg::ADDR_PC_HIGH[6:0]: pc_high_q <= result_v;
            bfau_pkg::ADDR_INT_CTRL[6:0]: int_ctrl_q <= result_v;
            default: begin
               if (map_addr == bfau_pkg::ADDR_OPTION) begin
                  option_q <= result_v;
               end
            end
         endcase
      end
   end

   // general purpose storage has no reset by design
   always_ff @(posedge core_clk) begin
      if (write_file && !map_addr[7] && map_addr[6:0] >= bfau_pkg::GPR_LOW_FIRST) begin
         ram_low[7'(map_addr[6:0] - bfau_pkg::GPR_LOW_FIRST)] <= result_v;
      end
      if (HIGH_GPR && write_file && map_addr[7] && map_addr[6:0] >= bfau_pkg::GPR_LOW_FIRST
          && map_addr[6:0] <= bfau_pkg::GPR_HIGH_LAST) begin
         ram_high[5'(map_addr[6:0] - bfau_pkg::GPR_LOW_FIRST)] <= result_v;
      end
   end

   // other registers (timer, ports, pcl, direction) live in neighbour blocks
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         read_q <= bfau_pkg::BYTE_ZERO;
         wdata_q <= bfau_pkg::BYTE_ZERO;
         waddr_q <= bfau_pkg::BYTE_ZERO;
         wext_q <= 1'b0;
      end else begin
         read_q <= file_ok ? file_val : bfau_pkg::BYTE_ZERO;
         wdata_q <= result_v;
         waddr_q <= map_addr;
         wext_q <= write_file && map_addr[6:0] != bfau_pkg::ADDR_INDIRECT[6:0];
      end
   end

   assign accumulator = acc_q;
   assign status_flags = status_q;
   assign read_data = read_q;
   assign write_data = wdata_q;
   assign write_addr = waddr_q;
   assign write_ext = wext_q;
   assign pc_high_latch = pc_high_q;
   assign interrupt_control = int_ctrl_q;
   assign option_config = option_q;
   assign indirect_pointer = pointer_q;

   status_mirror_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      exec_valid && !use_literal && exec_op == bfau_pkg::OP_PASS && map_addr[6:0] == bfau_pkg::ADDR_STATUS[6:0]
      |=> read_data == $past(status_q))
      else $error("status read differs between banks");
   flag_ro_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !sleep_cmd && !watchdog_clear_cmd && !watchdog_timeout |=> $stable(status_q[4:3]))
      else $error("timeout or sleep flag changed by a write");
   sub_borrow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      exec_valid && exec_op == bfau_pkg::OP_SUB |=> status_q[0] == ($past(opnd) >= $past(acc_q)))
      else $error("subtract carry is not the inverted borrow");
   zero_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      exec_valid && exec_op == bfau_pkg::OP_AND |=> status_q[2] == (($past(acc_q) & $past(opnd)) == 8'h00))
      else $error("zero flag wrong after logic op");
   bitop_flags_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      exec_valid && (exec_op == bfau_pkg::OP_BIT_SET || exec_op == bfau_pkg::OP_NIBBLE_SWAP) && !write_status
      |=> $stable(status_q[2:0]))
      else $error("flag moved on a flag-neutral op");
   zero_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      exec_valid && exec_op == bfau_pkg::OP_ZEROING && write_status |=> status_q[2] && status_q[7:5] == 3'h0)
      else $error("zeroing status did not set zero flag");
   // checks sample one edge after the taking edge; reset disables them
   unimpl_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      eff_addr inside {8'h07, 8'h08, 8'h09, 8'h0D, 8'h0E} |=> read_data == 8'h00)
      else $error("unimplemented address read nonzero");
   status_store_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      exec_valid && exec_op == bfau_pkg::OP_NONE && write_status |=> status_q[2:0] == $past(acc_q[2:0]))
      else $error("accumulator store to status lost a flag bit");
   zero_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      exec_valid && exec_op == bfau_pkg::OP_ZEROING && write_status |=> status_q[1:0] == $past(status_q[1:0]))
      else $error("zeroing status overwrote carry bits");
   indirect_redirect_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      write_file && file_addr == 7'h00 && !pointer_q[7] |=> write_addr == $past(pointer_q))
      else $error("indirect write not redirected through pointer");
   pc_high_latch_mirror_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      write_file && exec_op == bfau_pkg::OP_NONE && file_addr == 7'h0A |=> pc_high_latch == $past(acc_q))
      else $error("pc high latch store lost");
   acc_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      write_file |=> $stable(acc_q))
      else $error("accumulator changed by file write");
   sleep_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      sleep_cmd && !watchdog_clear_cmd |=> status_q[4:3] == 2'b10)
      else $error("sleep did not set flags");
   cover_sub_c: cover property (@(posedge core_clk) exec_valid && exec_op == bfau_pkg::OP_SUB);
   cover_indirect_c: cover property (@(posedge core_clk) exec_valid && file_addr == 7'h00);
   cover_status_c: cover property (@(posedge core_clk) write_status);
   cover_high_bank_c: cover property (@(posedge core_clk) exec_valid && eff_addr[7]);
   cover_sleep_c: cover property (@(posedge core_clk) sleep_cmd);
endmodule // bfau_core

// File: dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      bfau_pkg::alu_op_t op;
      logic [7:0] lit;
      logic [7:0] acc;
      logic [2:0] flg;
      logic [2:0] fmask;
   } row_t;

   logic core_clk, reset_n, exec_valid, use_literal, dest_file;
   logic sleep_cmd, watchdog_clear_cmd, watchdog_timeout;
   bfau_pkg::alu_op_t exec_op;
   logic [6:0] file_addr;
   logic [7:0] literal, timer_in, port_a_in, port_b_in, pc_low_in;
   logic [2:0] bit_sel;
   logic [7:0] accumulator, status_flags, read_data, write_data, write_addr;
   logic [7:0] pc_high_latch, interrupt_control, option_config, indirect_pointer;
   logic write_ext;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   row_t rows [9];

   bfau_core dut (
      .core_clk(core_clk), .reset_n(reset_n), .exec_valid(exec_valid), .exec_op(exec_op),
      .file_addr(file_addr), .use_literal(use_literal), .literal(literal), .bit_sel(bit_sel),
      .dest_file(dest_file), .sleep_cmd(sleep_cmd), .watchdog_clear_cmd(watchdog_clear_cmd),
      .watchdog_timeout(watchdog_timeout), .timer_in(timer_in), .port_a_in(port_a_in),
      .port_b_in(port_b_in), .pc_low_in(pc_low_in), .accumulator(accumulator),
      .status_flags(status_flags), .read_data(read_data), .write_data(write_data),
      .write_addr(write_addr), .write_ext(write_ext), .pc_high_latch(pc_high_latch),
      .interrupt_control(interrupt_control), .option_config(option_config),
      .indirect_pointer(indirect_pointer)
   );

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // a hang would otherwise stall the run forever; the sequence needs about 115 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         conclude();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one instruction, held for exactly one taking edge, outputs sampled at the following low phase
   task automatic run(input bfau_pkg::alu_op_t op, input logic [6:0] fa, input logic lit_en,
                      input logic [7:0] lit, input logic [2:0] bs, input logic dst);
      @(posedge core_clk);
      exec_valid <= 1'b1;
      exec_op <= op;
      file_addr <= fa;
      use_literal <= lit_en;
      literal <= lit;
      bit_sel <= bs;
      dest_file <= dst;
      @(posedge core_clk);
      exec_valid <= 1'b0;
      @(negedge core_clk);
   endtask

   task automatic lit_op(input bfau_pkg::alu_op_t op, input logic [7:0] lit);
      run(op, 7'h00, 1'b1, lit, 3'h0, 1'b0);
   endtask

   task automatic store(input logic [6:0] fa);
      run(bfau_pkg::OP_NONE, fa, 1'b0, 8'h00, 3'h0, 1'b1);
   endtask

   task automatic load(input logic [6:0] fa);
      run(bfau_pkg::OP_PASS, fa, 1'b0, 8'h00, 3'h0, 1'b0);
   endtask

   task automatic bank(input logic hi);
      run(hi ? bfau_pkg::OP_BIT_SET : bfau_pkg::OP_BIT_CLEAR, 7'h03, 1'b0, 8'h00, 3'h5, 1'b1);
   endtask

   task automatic pulse(input logic [2:0] p);
      @(posedge core_clk);
      {sleep_cmd, watchdog_clear_cmd, watchdog_timeout} <= p;
      @(posedge core_clk);
      {sleep_cmd, watchdog_clear_cmd, watchdog_timeout} <= 3'h0;
      @(negedge core_clk);
   endtask

   task automatic reset_values();
      check("accumulator", accumulator, bfau_pkg::BYTE_ZERO);
      check("status", status_flags, bfau_pkg::STATUS_RESET);
      check("option", option_config, bfau_pkg::OPTION_RESET);
      check("pointer", indirect_pointer, bfau_pkg::BYTE_ZERO);
      check("pc_high", pc_high_latch, bfau_pkg::BYTE_ZERO);
      check("int_ctrl", interrupt_control, bfau_pkg::BYTE_ZERO);
      check("read_reset", read_data, bfau_pkg::BYTE_ZERO);
      check("write_ext_reset", {7'h00, write_ext}, bfau_pkg::BYTE_ZERO);
   endtask

   initial begin
      reset_n = 1'b0;
      exec_valid = 1'b0;
      exec_op = bfau_pkg::OP_PASS;
      file_addr = 7'h00;
      use_literal = 1'b0;
      literal = 8'h00;
      bit_sel = 3'h0;
      dest_file = 1'b0;
      sleep_cmd = 1'b0;
      watchdog_clear_cmd = 1'b0;
      watchdog_timeout = 1'b0;
      timer_in = 8'h00;
      port_a_in = 8'h96;
      port_b_in = 8'h00;
      pc_low_in = 8'h5A;
      // flags are {zero, nibble carry, carry}; a zero mask skips ops whose flag effect is left open
      rows[0] = '{bfau_pkg::OP_PASS, 8'h3C, 8'h3C, 3'h0, 3'h0};
      rows[1] = '{bfau_pkg::OP_ADD, 8'hC8, 8'h04, 3'h3, 3'h7};
      rows[2] = '{bfau_pkg::OP_SUB, 8'h04, 8'h00, 3'h7, 3'h7};
      rows[3] = '{bfau_pkg::OP_PASS, 8'h12, 8'h12, 3'h0, 3'h0};
      rows[4] = '{bfau_pkg::OP_SUB, 8'h01, 8'hEF, 3'h0, 3'h7};
      rows[5] = '{bfau_pkg::OP_AND, 8'h0F, 8'h0F, 3'h0, 3'h4};
      rows[6] = '{bfau_pkg::OP_XOR, 8'h0F, 8'h00, 3'h4, 3'h4};
      rows[7] = '{bfau_pkg::OP_IOR, 8'hA5, 8'hA5, 3'h0, 3'h4};
      rows[8] = '{bfau_pkg::OP_ADD, 8'h5B, 8'h00, 3'h7, 3'h7};
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      @(negedge core_clk);
      reset_values();
      foreach (rows[i]) begin
         lit_op(rows[i].op, rows[i].lit);
         check("acc_row", accumulator, rows[i].acc);
         check("flags_row", 8'(status_flags[2:0] & rows[i].fmask), 8'(rows[i].flg & rows[i].fmask));
      end
      // status writes: top bits land, power flags hold, flag ops keep logic-produced flags
      lit_op(bfau_pkg::OP_PASS, 8'h22);
      store(7'h03);
      check("status_store", status_flags, 8'h3A);
      run(bfau_pkg::OP_ZEROING, 7'h03, 1'b0, 8'h00, 3'h0, 1'b1);
      check("status_zeroed", status_flags, 8'h1E);
      pulse(3'b100);
      check("status_sleep", status_flags, 8'h16);
      pulse(3'b001);
      check("status_timeout", status_flags, 8'h06);
      pulse(3'b010);
      check("status_wd_clear", status_flags, 8'h1E);
      bank(1'b1);
      check("status_bitset", status_flags, 8'h3E);
      lit_op(bfau_pkg::OP_PASS, 8'hAA);
      store(7'h20);
      // the literal move cleared zero; the bank bit is cleared through the high-bank copy
      bank(1'b0);
      check("status_mirror", status_flags, 8'h1A);
      lit_op(bfau_pkg::OP_PASS, 8'h55);
      store(7'h20);
      load(7'h20);
      check("bank_low", accumulator, 8'h55);
      bank(1'b1);
      load(7'h20);
      check("bank_high", accumulator, 8'hAA);
      lit_op(bfau_pkg::OP_PASS, 8'h6C);
      store(7'h70);
      lit_op(bfau_pkg::OP_PASS, 8'h4D);
      store(7'h0A);
      check("pc_high_mirror", pc_high_latch, 8'h4D);
      load(7'h02);
      check("pc_low_high_bank", accumulator, 8'h5A);
      store(7'h0B);
      check("int_ctrl_mirror", interrupt_control, 8'h5A);
      store(7'h01);
      check("option_high_bank", option_config, 8'h5A);
      load(7'h03);
      check("status_high_read", accumulator, 8'h3A);
      check("status_read_data", read_data, 8'h3A);
      bank(1'b0);
      load(7'h70);
      check("common_ram", accumulator, 8'h6C);
      load(7'h07);
      check("unimplemented", accumulator, 8'h00);
      load(7'h05);
      check("port_read", accumulator, 8'h96);
      check("port_read_data", read_data, 8'h96);
      lit_op(bfau_pkg::OP_PASS, 8'h3C);
      store(7'h05);
      check("write_ext", {7'h00, write_ext}, 8'h01);
      check("write_addr", write_addr, 8'h05);
      check("write_data", write_data, 8'h3C);
      // indirect path through the pointer
      lit_op(bfau_pkg::OP_PASS, 8'h21);
      store(7'h04);
      check("pointer", indirect_pointer, 8'h21);
      lit_op(bfau_pkg::OP_PASS, 8'h77);
      store(7'h00);
      lit_op(bfau_pkg::OP_PASS, 8'h00);
      load(7'h21);
      check("indirect_write", accumulator, 8'h77);
      // rotate through carry from a file operand
      lit_op(bfau_pkg::OP_PASS, 8'h81);
      store(7'h22);
      run(bfau_pkg::OP_BIT_CLEAR, 7'h03, 1'b0, 8'h00, 3'h0, 1'b1);
      run(bfau_pkg::OP_ROTATE_LEFT, 7'h22, 1'b0, 8'h00, 3'h0, 1'b0);
      check("rotate_acc", accumulator, 8'h02);
      check("rotate_carry", {7'h00, status_flags[0]}, 8'h01);
      run(bfau_pkg::OP_NIBBLE_SWAP, 7'h22, 1'b0, 8'h00, 3'h0, 1'b0);
      check("swap_acc", accumulator, 8'h18);
      check("swap_flags", {5'h00, status_flags[2:0]}, 8'h03);
      // second reset in mid-run
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(negedge core_clk);
      reset_values();
      lit_op(bfau_pkg::OP_PASS, 8'h42);
      check("acc_after_reset", accumulator, 8'h42);
      conclude();
   end
endmodule // testbench
